// >>> core/acbhp_conv_if.sv
// ------------------------------------------------------------
// sequencer to result path bundle
// ------------------------------------------------------------
interface acbhp_conv_if;
    logic       tick;      // one conversion clock tick
    logic       start;     // begin acquisition
    logic       hold;      // end external acquisition
    logic       busy;      // acquisition or conversion running
    logic       done;      // conversion finished pulse

    modport seq (input tick, input start, input hold, output busy, output done);
    modport top (output tick, output start, output hold, input busy, input done);
endinterface

// >>> core/acbhp_pkg.sv
package acbhp_pkg;
    // ------------------------------------------------------------
    // Notes on behaviour
    // ------------------------------------------------------------
    // Notes on behaviour
    // [RULE_01] top two bits pick power and clock mode
    // [RULE_02] power-down keeps last requested clock mode
    // [RULE_03] external clock mode after reset
    // [RULE_04] bit 5 picks internal or external acquisition
    // [RULE_05] both acquisition modes under both clocks
    // [RULE_06] bit 4 picks single-ended or pseudo-differential
    // [RULE_07] bit 3 picks unipolar or bipolar range
    // [RULE_08] bits 2..0 are the channel address
    // [RULE_09] single-ended: channel n plus, common minus
    // [RULE_10] differential: pair by upper bits, low picks plus
    // [RULE_11] four-channel variant only addresses channels 0..3
    // [RULE_12] internal clock gives about 3.6 us conversion
    // [RULE_13] host ties clock pin when clock is internal
    // [RULE_14] host clock 100 kHz to 7.6 MHz
    // [RULE_15] chip-select high ignores strobes, bus released
    // [RULE_16] write with chip-select captures control byte
    // [RULE_17] straight binary unipolar, two's complement bipolar
    // [RULE_18] host holds select and read low to read
    // [RULE_19] upper select picks low byte or bits 9..8
    // [RULE_20] upper byte fills with zero or sign
    // [RULE_21] done low at finish, cleared by read or write
    // [RULE_22] conversion lasts exactly 13 conversion clocks
    // [RULE_23] internal acquisition is three clocks or 1 us
    // [RULE_24] second write ends external acquisition on rise
    // [RULE_25] drive bus only while select and read low

    // ------------------------------------------------------------
    // control byte fields
    // ------------------------------------------------------------
    localparam int CTL_PWR_HI_BIT  = 7;
    localparam int CTL_PWR_LO_BIT  = 6;
    localparam int CTL_ACQ_BIT     = 5;
    localparam int CTL_TOPO_BIT    = 4;
    localparam int CTL_POL_BIT     = 3;
    localparam int CTL_ADDR_MSB    = 2;
    localparam logic [7:0] CTL_RESET = 8'hC8; // external clock, normal, unipolar
    localparam logic       CLK_EXT_RESET = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int  SYS_CLK_HZ         = 40_000_000;
    localparam real CONV_TIME_US       = 3.6;
    localparam real ACQ_TIME_US        = 1.0;
    localparam int  CONV_CYCLES        = 13;
    localparam int  ACQ_EXT_CYCLES     = 3;
    // conversion clock period so that 13 ticks make about 3.6 us
    localparam int  INT_TICK_SYS = int'($floor(CONV_TIME_US * SYS_CLK_HZ / 1.0e6 / CONV_CYCLES));
    localparam int  ACQ_INT_TICKS = int'($floor(ACQ_TIME_US * SYS_CLK_HZ / 1.0e6 / INT_TICK_SYS));

    typedef enum logic [1:0] {
        PWR_FULL_DOWN = 2'h0,
        PWR_STANDBY   = 2'h1,
        PWR_NORM_INT  = 2'h2,
        PWR_NORM_EXT  = 2'h3
    } acbhp_pwr_t;
endpackage

// >>> core/acbhp_seq.sv
// ------------------------------------------------------------
// acquisition and 13-tick conversion sequencer
// ------------------------------------------------------------
module acbhp_seq
    import acbhp_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    input  wire logic  ext_acq,
    input  wire logic  clk_internal,
    acbhp_conv_if.seq  cv
);
    typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV} acbhp_seq_t;
    acbhp_seq_t state;
    logic [4:0] cnt;   // ticks in current phase

    wire [4:0] acq_len = clk_internal ? 5'(ACQ_INT_TICKS) : 5'(ACQ_EXT_CYCLES);

    // new write restarts acquisition, aborting any conversion, except that hold wins during acquisition
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state   <= S_IDLE;
            cnt     <= 5'h00;
            cv.done <= 1'b0;
        end
        else
        begin
            cv.done <= 1'b0;
            if (cv.hold && state == S_ACQ)
            begin
                state <= S_CONV; // [RULE_24]
                cnt   <= 5'h00;
            end
            else if (cv.start)
            begin
                state <= S_ACQ;
                cnt   <= 5'h00;
            end
            else if (cv.tick)
            begin
                unique case (state)
                    S_IDLE: ;
                    S_ACQ:
                    begin
                        // internally timed acquisition ends by itself
                        if (!ext_acq && cnt == acq_len - 5'h01) // [RULE_23] [RULE_05]
                        begin
                            state <= S_CONV;
                            cnt   <= 5'h00;
                        end
                        else if (!ext_acq)
                            cnt <= cnt + 5'h01;
                    end
                    S_CONV:
                    begin
                        if (cnt == 5'(CONV_CYCLES - 1)) // [RULE_22]
                        begin
                            state   <= S_IDLE;
                            cv.done <= 1'b1;
                        end
                        else
                            cnt <= cnt + 5'h01;
                    end
                endcase
            end
        end
    end

    assign cv.busy = (state != S_IDLE);
endmodule

// >>> core/acbhp_tick_gen.sv
// ------------------------------------------------------------
// internal conversion clock divider
// ------------------------------------------------------------
module acbhp_tick_gen
    import acbhp_pkg::*;
#(
    parameter int DIV = INT_TICK_SYS
)(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic run,
    output logic      tick
);
    // the cycle counter below is sixteen bits wide
    if (DIV < 1 || DIV > 65536) $error("divider must be 1 to 65536");

    logic [15:0] cnt; // cycles since last tick
    wire         wrap = (cnt == 16'(DIV - 1));

    // free counter while enabled, restarted when idle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt <= 16'h0000;
        else if (!run || wrap)
            cnt <= 16'h0000;
        else
            cnt <= cnt + 16'h0001;
    end

    assign tick = run && wrap; // [RULE_12]
endmodule

// >>> core/acbhp_top.sv
// ------------------------------------------------------------
// converter control byte and host port
// ------------------------------------------------------------
module acbhp_top
    import acbhp_pkg::*;
#(
    parameter int NUM_CH = 8 // 8 or 4 channel variant
)(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       cs_n,          // chip select
    input  wire logic       wr_n,          // write strobe
    input  wire logic       rd_n,          // read strobe
    input  wire logic       upper_byte_sel,
    input  wire logic       conv_clk,      // external conversion clock, sampled
    input  wire logic [9:0] sample_code,   // raw code from the analog core
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic      [7:0] data_oe_n,     // low while driving
    output logic            done_n,
    output logic            clk_internal,
    output logic            power_down,
    output logic            standby,
    output logic            ext_acq,
    output logic            single_ended,
    output logic            unipolar,
    output logic      [2:0] pos_channel,
    output logic      [2:0] neg_channel,
    output logic            neg_is_common,
    output logic            addr_fault
);
    if (NUM_CH != 8 && NUM_CH != 4) $error("channel count must be 4 or 8");

    // ------------------------------------------------------------
    // host strobes
    // ------------------------------------------------------------
    logic [7:0] conversion_control_byte; // last written control byte
    logic       wr_q;                    // delayed qualified write
    logic       rd_q;                    // delayed qualified read
    logic       cclk_q;                  // delayed external clock
    logic [9:0] result;                  // latched conversion result

    wire wr_act   = !cs_n && !wr_n;             // [RULE_15]
    wire rd_act   = !cs_n && !rd_n;             // [RULE_15]
    wire wr_rise  = wr_q && !wr_act;            // end of write pulse
    wire rd_fall  = rd_act && !rd_q;            // first cycle of read
    wire cclk_en  = !cs_n;                      // clock pin ignored while deselected [RULE_15]
    wire ext_tick = cclk_en && conv_clk && !cclk_q;

    // edge history of strobes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            cclk_q <= 1'b0;
        end
        else
        begin
            wr_q   <= wr_act;
            rd_q   <= rd_act;
            cclk_q <= conv_clk;
        end
    end

    // ------------------------------------------------------------
    // control byte and clock mode
    // ------------------------------------------------------------
    // byte stored on the closing edge so data is settled
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conversion_control_byte <= CTL_RESET;
            clk_internal            <= ~CLK_EXT_RESET; // [RULE_03]
        end
        else if (wr_rise)
        begin
            conversion_control_byte <= data_in; // [RULE_16]
            // power-down codes leave clock choice alone
            if (data_in[CTL_PWR_HI_BIT]) // [RULE_01] [RULE_02]
                clk_internal <= !data_in[CTL_PWR_LO_BIT];
        end
    end

    wire acbhp_pwr_t pwr = acbhp_pwr_t'(conversion_control_byte[CTL_PWR_HI_BIT:CTL_PWR_LO_BIT]);
    wire [2:0] addr = conversion_control_byte[CTL_ADDR_MSB:0]; // [RULE_08]

    assign power_down   = (pwr == PWR_FULL_DOWN); // [RULE_01]
    assign standby      = (pwr == PWR_STANDBY);
    assign ext_acq      = conversion_control_byte[CTL_ACQ_BIT];  // [RULE_04]
    assign single_ended = conversion_control_byte[CTL_TOPO_BIT]; // [RULE_06]
    assign unipolar     = conversion_control_byte[CTL_POL_BIT];  // [RULE_07]

    // ------------------------------------------------------------
    // multiplexer selection
    // ------------------------------------------------------------
    assign pos_channel   = addr;                                    // [RULE_09] [RULE_10]
    assign neg_channel   = single_ended ? addr : {addr[2:1], ~addr[0]}; // [RULE_10]
    assign neg_is_common = single_ended;                            // [RULE_09]
    // upper channels absent on the small variant
    assign addr_fault    = (NUM_CH == 4) && addr[2];                // [RULE_11]

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    acbhp_conv_if cv ();
    logic int_tick;

    acbhp_tick_gen #(.DIV(INT_TICK_SYS)) u_tick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (clk_internal && cv.busy),
        .tick    (int_tick)
    );

    // second write of an external acquisition ends it; any other write restarts unless it addresses an absent channel
    wire second_wr = wr_rise && ext_acq && !data_in[CTL_ACQ_BIT];
    // absent channels judged on the byte being written, not the stored one
    wire new_fault = (NUM_CH == 4) && data_in[CTL_ADDR_MSB];
    assign cv.tick  = clk_internal ? int_tick : ext_tick; // [RULE_12]
    assign cv.hold  = second_wr;                             // [RULE_24]
    // hold wins inside the sequencer while acquiring, so start may stand with it
    assign cv.start = wr_rise && !new_fault;                 // [RULE_11]

    acbhp_seq u_seq (
        .sys_clk      (sys_clk),
        .arst_n       (arst_n),
        .ext_acq      (ext_acq),
        .clk_internal (clk_internal),
        .cv           (cv)
    );

    // ------------------------------------------------------------
    // result and done flag
    // ------------------------------------------------------------
    // code from the core already carries the chosen coding
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            result <= 10'h000;
        else if (cv.done)
            result <= sample_code; // [RULE_17]
    end

    // done set wins over a read in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            done_n <= 1'b1;
        else if (cv.done)
            done_n <= 1'b0;        // [RULE_21]
        else if (rd_fall || wr_rise)
            done_n <= 1'b1;        // [RULE_21]
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    wire [7:0] fill     = unipolar ? 8'h00 : {8{result[9]}};            // [RULE_20]
    wire [7:0] rd_value = upper_byte_sel ? {fill[7:2], result[9:8]}     // [RULE_19]
                                         : result[7:0];

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            data_out <= 8'h00;
        else
            data_out <= rd_value;
    end

    // drivers follow strobes combinationally
    assign data_oe_n = rd_act ? 8'h00 : 8'hFF; // [RULE_25] [RULE_15]
endmodule

// >>> test/acbhp_host_model.sv
// ------------------------------------------------------------
// microprocessor on the byte bus plus conversion clock source
// ------------------------------------------------------------
module acbhp_host_model
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic            upper_byte_sel,
    output logic      [7:0] data_in,
    output logic            conv_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_run; // conversion clock enable
    logic [2:0] div;     // divide by 8: 5 MHz, 50 percent duty
    initial
    begin
        {cs_n, wr_n, rd_n} = 3'h7;
        upper_byte_sel = 1'b0;
        data_in = 8'h00;
        clk_run = 1'b1;
        div = 3'h0;
        conv_clk = 1'b0;
    end
    // parked low in internal mode so the pin never floats
    always @(posedge sys_clk)
    begin
        div <= div + 3'h1;
        conv_clk <= clk_run & div[2];
    end
    // write: data held through the strobe rise
    task automatic write_ctl(input logic [7:0] b, input logic sel);
        @(posedge sys_clk);
        cs_n <= !sel;
        wr_n <= 1'b0;
        data_in <= b;
        @(posedge sys_clk);
        wr_n <= 1'b1;
        @(posedge sys_clk);
        // select left as set so an external conversion clock keeps reaching the part
        data_in <= ~b; // released bus drifts
    endtask
    // read: select and strobe low together, data taken at edge
    task automatic read_res(input logic hi, output logic [7:0] d);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        upper_byte_sel <= hi;
        repeat (2) @(posedge sys_clk);
        d = data_out;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
endmodule

// >>> test/acbhp_properties.sv
module acbhp_properties
    import acbhp_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic       upper_byte_sel,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic       done_n,
    input wire logic       clk_internal,
    input wire logic       ext_acq,
    input wire logic       single_ended,
    input wire logic       unipolar,
    input wire logic [2:0] pos_channel,
    input wire logic [2:0] neg_channel,
    input wire logic       neg_is_common
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // qualified write ends: strobe back up, select still low
    // ------------------------------------------------------------
    sequence s_wr_end;
        !cs_n && wr_n && $past(!cs_n && !wr_n);
    endsequence
    a_bus_release: assert property (cs_n |-> data_oe_n == 8'hFF)
        else $error("bus driven without chip select");
    a_bus_drive: assert property (!cs_n && !rd_n |-> data_oe_n == 8'h00)
        else $error("bus not driven during read");
    a_clk_int: assert property (s_wr_end ##0 data_in[7:6] == 2'h2 |-> ##[1:2] clk_internal)
        else $error("internal clock not selected");
    a_pd_keep: assert property (s_wr_end ##0 !data_in[7] |=> clk_internal == $past(clk_internal))
        else $error("power-down changed clock mode");
    a_field_load: assert property (s_wr_end |=> ext_acq == $past(data_in[5])
        && single_ended == $past(data_in[4]) && unipolar == $past(data_in[3]))
        else $error("control fields not loaded");
    a_single_sel: assert property (s_wr_end ##0 data_in[4] |=>
        pos_channel == $past(data_in[2:0]) && neg_is_common)
        else $error("single-ended channel wrong");
    a_diff_pair: assert property (!single_ended |-> !neg_is_common && neg_channel == (pos_channel ^ 3'h1))
        else $error("differential pair wrong");
    a_upper_fill: assert property ($past(!cs_n && !rd_n && upper_byte_sel) |->
        data_out[7:2] == ($past(unipolar) ? 6'h00 : {6{data_out[1]}}))
        else $error("upper byte fill wrong");
    a_read_clear: assert property ($fell(rd_n) && !cs_n && !done_n |-> ##[1:2] done_n)
        else $error("done not cleared by read");
endmodule

bind acbhp_top acbhp_properties u_props (
    .sys_clk        (sys_clk),
    .arst_n         (arst_n),
    .cs_n           (cs_n),
    .wr_n           (wr_n),
    .rd_n           (rd_n),
    .upper_byte_sel (upper_byte_sel),
    .data_in        (data_in),
    .data_out       (data_out),
    .data_oe_n      (data_oe_n),
    .done_n         (done_n),
    .clk_internal   (clk_internal),
    .ext_acq        (ext_acq),
    .single_ended   (single_ended),
    .unipolar       (unipolar),
    .pos_channel    (pos_channel),
    .neg_channel    (neg_channel),
    .neg_is_common  (neg_is_common)
);

// >>> test/adc_control_byte_host_port_tb.sv
module adc_control_byte_host_port_tb
    import acbhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk, arst_n, cs_n, wr_n, rd_n, upper_byte_sel, conv_clk;
    logic [9:0] sample_code;
    logic [7:0] data_in, data_out, data_oe_n, d;
    logic       done_n, clk_internal, power_down, standby, ext_acq, addr_fault;
    logic       single_ended, unipolar, neg_is_common;
    logic [2:0] pos_channel, neg_channel;
    int         miscompares, check_count, ticks, n;
    localparam int EXP_INT = (ACQ_INT_TICKS + CONV_CYCLES) * INT_TICK_SYS;
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge conv_clk) ticks++;
    acbhp_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .upper_byte_sel(upper_byte_sel), .conv_clk(conv_clk), .sample_code(sample_code),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .done_n(done_n),
        .clk_internal(clk_internal), .power_down(power_down), .standby(standby), .ext_acq(ext_acq),
        .single_ended(single_ended), .unipolar(unipolar), .pos_channel(pos_channel),
        .neg_channel(neg_channel), .neg_is_common(neg_is_common), .addr_fault(addr_fault));
    acbhp_host_model host (.sys_clk(sys_clk), .data_out(data_out), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .upper_byte_sel(upper_byte_sel), .data_in(data_in), .conv_clk(conv_clk));
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    // bounded wait for result ready
    task automatic wait_done();
        n = 0;
        while (done_n !== 1'b0 && n < 2000)
        begin
            @(posedge sys_clk);
            n++;
        end
        // a hang counts against the run
        if (n >= 2000)
            miscompares++;
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: whole run is under two thousand cycles
    initial
    begin
        #500000;
        miscompares++;
        end_of_test();
    end
    initial
    begin
        arst_n = 1'b0;
        sample_code = 10'h2A5;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        check(clk_internal, 1'b0);
        check(data_oe_n, 8'hFF);
        host.write_ctl(8'hD8, 1'b1);
        ticks = 0;
        wait_done();
        check(ticks inside {16, 17}, 1'b1);
        host.read_res(1'b0, d);
        check(d, 8'hA5);
        check(done_n, 1'b1);
        host.read_res(1'b1, d);
        check(d, 8'h02);
        host.write_ctl(8'hD0, 1'b1);
        wait_done();
        host.read_res(1'b1, d);
        check(d, 8'hFE);
        host.write_ctl(8'hD0, 1'b1);
        host.write_ctl(8'h08, 1'b0);
        repeat (300) @(posedge sys_clk);
        check(done_n, 1'b1);
        check({power_down, single_ended}, 2'h1);
        host.clk_run <= 1'b0;
        host.write_ctl(8'h98, 1'b1);
        ticks = 0;
        wait_done();
        check(clk_internal, 1'b1);
        check(n inside {[EXP_INT - 2 : EXP_INT + INT_TICK_SYS]}, 1'b1);
        check(ticks, 0);
        host.write_ctl(8'h18, 1'b1);
        @(posedge sys_clk);
        check({power_down, standby, clk_internal}, 3'h5);
        host.write_ctl(8'h58, 1'b1);
        @(posedge sys_clk);
        check({power_down, standby, clk_internal}, 3'h3);
        for (int i = 0; i < 2; i++)
        begin
            host.clk_run <= i[0];
            host.write_ctl(i[0] ? 8'hF8 : 8'hB8, 1'b1);
            repeat (300) @(posedge sys_clk);
            check({done_n, ext_acq, clk_internal}, {2'h3, !i[0]});
            host.write_ctl(i[0] ? 8'hD8 : 8'h98, 1'b1);
            wait_done();
            check(n <= (CONV_CYCLES + 2) * INT_TICK_SYS, 1'b1);
        end
        for (int a = 0; a < 8; a++)
        begin
            host.write_ctl(8'hD8 | a[7:0], 1'b1);
            @(posedge sys_clk);
            check({neg_is_common, pos_channel}, {1'b1, a[2:0]});
            check(addr_fault, 1'b0);
            host.write_ctl(8'hC8 | a[7:0], 1'b1);
            @(posedge sys_clk);
            check({pos_channel, neg_channel}, {a[2:0], a[2:1], ~a[0]});
        end
        end_of_test();
    end
endmodule
